// ==== bench/dtc_pin_src.sv ====
// Count pin source model for the timer/counter block
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_src (
    input wire logic mclk_i,
    output logic pin_o
);
    // Idle high, so a stopped source never fakes a falling edge
    initial pin_o = 1'b1;

    // Each level stands one full machine cycle before it changes
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (dtc_pkg::PRE_DIV) @(posedge mclk_i);
            pin_o <= 1'b0;
            repeat (dtc_pkg::PRE_DIV) @(posedge mclk_i);
            pin_o <= 1'b1;
        end
    endtask : pulses
endmodule : dtc_pin_src
`default_nettype wire

// ==== bench/dtc_top_asserts.sv ====
// Port checker for the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none
module dtc_top_asserts (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [1:0] count_pin_i,
    input wire logic [1:0] ext_irq_pin_i,
    input wire logic [1:0] tmr_ack_i,
    input wire logic [1:0] ext_ack_i,
    input wire logic [7:0] rdata_o,
    input wire logic [1:0] ovf_pulse_o,
    input wire logic [1:0] tmr_flag_o,
    input wire logic [1:0] ext_flag_o,
    input wire logic [1:0] clk_out_o,
    input wire logic [1:0] clk_out_oe_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // Read data only stands in the cycle after a read
    a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not idle");
    a_unmapped_zero: assert property (rd_i && addr_i < 8'h88 |=>
        rdata_o == 8'h00) else $error("unmapped read not zero");
    a_mode_readback: assert property (
        wr_i && addr_i == dtc_pkg::ADDR_TMODE ##2
        rd_i && addr_i == dtc_pkg::ADDR_TMODE |=> rdata_o == $past(wdata_i, 3))
        else $error("mode register readback wrong");
    a_clko_readback: assert property (
        wr_i && addr_i == dtc_pkg::ADDR_CLKO ##2
        rd_i && addr_i == dtc_pkg::ADDR_CLKO |=>
        rdata_o == ($past(wdata_i, 3) & dtc_pkg::CLKO_MASK))
        else $error("clock out register readback wrong");

    // Overflow side effects land together with the pulse
    a_pulse_flag: assert property (ovf_pulse_o[0] |-> tmr_flag_o[0])
        else $error("overflow pulse without flag");
    // The enable that counts is the one in force when the overflow happened
    a_clk_toggle: assert property (
        ovf_pulse_o[0] && $past(clk_out_oe_o[0]) |->
        clk_out_o[0] != $past(clk_out_o[0]))
        else $error("clock out did not toggle");
    a_clk_hold: assert property (
        ovf_pulse_o == 2'b00 |-> $stable(clk_out_o))
        else $error("clock out moved without overflow");
    a_flag_hold: assert property (
        tmr_flag_o[0] && !tmr_ack_i[0] && !wr_i |=> tmr_flag_o[0])
        else $error("overflow flag lost");
endmodule : dtc_top_asserts

bind dtc_top dtc_top_asserts u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .count_pin_i(count_pin_i), .ext_irq_pin_i(ext_irq_pin_i),
    .tmr_ack_i(tmr_ack_i), .ext_ack_i(ext_ack_i), .rdata_o(rdata_o),
    .ovf_pulse_o(ovf_pulse_o), .tmr_flag_o(tmr_flag_o),
    .ext_flag_o(ext_flag_o), .clk_out_o(clk_out_o),
    .clk_out_oe_o(clk_out_oe_o));
`default_nettype wire

// ==== bench/tb_dtc_top.sv ====
// Self-checking testbench for the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none
module tb_dtc_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] xpin = 2'b11;
    logic [1:0] tack = 2'b00;
    logic [1:0] xack = 2'b00;
    logic ce = 1'b1;
    wire logic [1:0] cpin;
    logic [7:0] rdata;
    logic [1:0] pulse, tflag, xflag, ckout, ckoe;
    int miscompares = 0;
    int tests_run = 0;

    // 25 MHz system clock
    always #20 clk = ~clk;

    dtc_pin_src src0 (.mclk_i(clk), .pin_o(cpin[0]));
    dtc_pin_src src1 (.mclk_i(clk), .pin_o(cpin[1]));

    // Clock enable is dropped once, while timer 0 runs
    dtc_top dut (.mclk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .count_pin_i(cpin),
        .ext_irq_pin_i(xpin), .tmr_ack_i(tack), .ext_ack_i(xack),
        .rdata_o(rdata), .ovf_pulse_o(pulse), .tmr_flag_o(tflag),
        .ext_flag_o(xflag), .clk_out_o(ckout), .clk_out_oe_o(ckoe));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One-cycle bus strobes, released at the edge that samples them
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask : rchk

    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // Interrupt pins change on a rising edge, flags judged once settled
    task automatic xdrive(input logic [1:0] v, input logic [7:0] e);
        @(posedge clk);
        xpin <= v;
        settle();
        chk(xflag, e);
    endtask : xdrive

    // Run bits stay set for exactly n clocks
    task automatic run_for(input logic [7:0] on, input int n);
        wr_reg(dtc_pkg::ADDR_TCTL, on);
        repeat (n - 2) @(posedge clk);
        wr_reg(dtc_pkg::ADDR_TCTL, 8'h00);
    endtask : run_for

    task automatic t_regs;
        for (int a = 8'h88; a <= 8'h8f; a++) begin
            rchk(8'(a), dtc_pkg::RST_REG);
        end
        rchk(8'h87, 8'h00);
        wr_reg(dtc_pkg::ADDR_CLKO, 8'hff);
        rchk(dtc_pkg::ADDR_CLKO, 8'h77);
        wr_reg(dtc_pkg::ADDR_CLKO, 8'h00);
        wr_reg(dtc_pkg::ADDR_TMODE, 8'ha5);
        rchk(dtc_pkg::ADDR_TMODE, 8'ha5);
        $display("register test done");
    endtask : t_regs

    task automatic t_timer;
        wr_reg(dtc_pkg::ADDR_TMODE, 8'h01);
        wr_reg(dtc_pkg::ADDR_TL0, 8'h10);
        wr_reg(dtc_pkg::ADDR_TH0, 8'h00);
        run_for(8'h10, 120);
        rchk(dtc_pkg::ADDR_TL0, 8'h1a);
        wr_reg(dtc_pkg::ADDR_AUX, 8'h80);
        run_for(8'h10, 100);
        rchk(dtc_pkg::ADDR_TL0, 8'h7e);
        // Ten frozen clocks inside a run: only three counting edges remain
        wr_reg(dtc_pkg::ADDR_TCTL, 8'h10);
        @(posedge clk);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        wr_reg(dtc_pkg::ADDR_TCTL, 8'h00);
        rchk(dtc_pkg::ADDR_TL0, 8'h81);
        $display("timer rate test done");
    endtask : t_timer

    task automatic t_count;
        wr_reg(dtc_pkg::ADDR_TMODE, 8'h5d);
        wr_reg(dtc_pkg::ADDR_TL0, 8'h00);
        wr_reg(dtc_pkg::ADDR_TL1, 8'h00);
        xpin <= 2'b10;
        wr_reg(dtc_pkg::ADDR_TCTL, 8'h50);
        fork
            src0.pulses(3);
            src1.pulses(4);
        join
        xpin <= 2'b11;
        src0.pulses(5);
        settle();
        rchk(dtc_pkg::ADDR_TL0, 8'h05);
        rchk(dtc_pkg::ADDR_TL1, 8'h04);
        wr_reg(dtc_pkg::ADDR_TCTL, 8'h00);
        $display("counter test done");
    endtask : t_count

    task automatic t_mode0;
        wr_reg(dtc_pkg::ADDR_TMODE, 8'h00);
        wr_reg(dtc_pkg::ADDR_TH0, 8'hff);
        wr_reg(dtc_pkg::ADDR_TL0, 8'hfe);
        run_for(8'h10, 2);
        rchk(dtc_pkg::ADDR_TH0, 8'h00);
        rchk(dtc_pkg::ADDR_TL0, 8'he0);
        rchk(dtc_pkg::ADDR_TCTL, 8'h20);
        $display("mode 0 test done");
    endtask : t_mode0

    task automatic t_reload;
        logic [7:0] n0, n1, t0, t1;
        logic [1:0] q;
        wr_reg(dtc_pkg::ADDR_TMODE, 8'h22);
        wr_reg(dtc_pkg::ADDR_AUX, 8'hc0);
        wr_reg(dtc_pkg::ADDR_TH0, 8'hfc);
        wr_reg(dtc_pkg::ADDR_TL0, 8'hfc);
        wr_reg(dtc_pkg::ADDR_TH1, 8'hfe);
        wr_reg(dtc_pkg::ADDR_TL1, 8'hfe);
        wr_reg(dtc_pkg::ADDR_CLKO, 8'h03);
        wr_reg(dtc_pkg::ADDR_TCTL, 8'h50);
        settle();
        {n0, n1, t0, t1} = '0;
        q = ckout;
        // Any 40 clocks hold exactly 40/period overflows
        repeat (40) begin
            @(negedge clk);
            n0 += pulse[0];
            n1 += pulse[1];
            t0 += ckout[0] ^ q[0];
            t1 += ckout[1] ^ q[1];
            q = ckout;
        end
        chk(n0, 8'h0a);
        chk(t0, 8'h0a);
        chk(n1, 8'h14);
        chk(t1, 8'h14);
        chk(tflag, 8'h03);
        // Stop both timers; a plain zero write would clear the flags too
        wr_reg(dtc_pkg::ADDR_TCTL, 8'ha0);
        wr_reg(dtc_pkg::ADDR_CLKO, 8'h00);
        rchk(dtc_pkg::ADDR_TH0, 8'hfc);
        rchk(dtc_pkg::ADDR_TCTL, 8'ha0);
        @(posedge clk);
        tack <= 2'b11;
        @(posedge clk);
        tack <= 2'b00;
        settle();
        chk(tflag, 8'h00);
        $display("reload test done");
    endtask : t_reload

    task automatic t_split;
        wr_reg(dtc_pkg::ADDR_TMODE, 8'h33);
        wr_reg(dtc_pkg::ADDR_TL0, 8'h00);
        wr_reg(dtc_pkg::ADDR_TH0, 8'h00);
        wr_reg(dtc_pkg::ADDR_TL1, 8'h50);
        run_for(8'h50, 20);
        rchk(dtc_pkg::ADDR_TL0, 8'h14);
        rchk(dtc_pkg::ADDR_TH0, 8'h14);
        rchk(dtc_pkg::ADDR_TL1, 8'h50);
        $display("split test done");
    endtask : t_split

    task automatic t_ext;
        xdrive(2'b01, 8'h02);
        xdrive(2'b11, 8'h00);
        wr_reg(dtc_pkg::ADDR_TCTL, 8'h05);
        xdrive(2'b00, 8'h03);
        xdrive(2'b11, 8'h03);
        @(posedge clk);
        xack <= 2'b01;
        @(posedge clk);
        xack <= 2'b00;
        settle();
        rchk(dtc_pkg::ADDR_TCTL, 8'h0d);
        wr_reg(dtc_pkg::ADDR_TCTL, 8'h00);
        $display("external flag test done");
    endtask : t_ext

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // Main sequence after a 20-clock reset
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_timer();
        t_count();
        t_mode0();
        t_reload();
        t_split();
        t_ext();
        end_of_test();
    end

    // Watchdog well beyond the several hundred clocks the tests need
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
endmodule : tb_dtc_top
`default_nettype wire

// ==== rtl/dtc_edge.sv ====
// Falling edge detectors for count and external interrupt pins
`timescale 1ns/1ps
`default_nettype none
module dtc_edge #(
    parameter int W = 4
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] fall_o
);
    typedef struct packed {
        logic [W-1:0] samp;
        logic [W-1:0] fall;
    } dtc_edge_st_t;

    dtc_edge_st_t s_ff;
    dtc_edge_st_t nxt_s;

    // Previous sample high and present sample low gives a registered pulse
    always_comb begin
        nxt_s.samp = pin_i;
        nxt_s.fall = s_ff.samp & ~pin_i;
    end

    // Reset samples low so a pin held low from reset gives no false edge
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_ff <= '0;
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    assign fall_o = s_ff.fall;
endmodule : dtc_edge
`default_nettype wire

// ==== rtl/dtc_pkg.sv ====
// Constants, types and register map of the dual timer/counter block
// Operation
// - Timer counts once per 12 clocks, or every clock with divide-select set
// - Counter function samples count pin each clock, counts on high-then-low
// - Counted value shows in register one cycle after the edge detection
// - Edge recognition path limits external count rate to one half of clock
// - Function-select bit picks internal clock when clear, count pin when set
// - Mode field: 00 13-bit, 01 16-bit, 10 8-bit reload, 11 split/hold
// - Timer counts only when run bit set and gate clear or pin high
// - Mode 0 counts high byte plus low five bits of low byte
// - Counter wrap from all ones to zero sets that timer's overflow flag, except timer 1 while timer 0 is in mode 3
// - Setting the run bit leaves both count bytes unchanged
// - Mode 1 cascades both count bytes into one 16-bit counter
// - Mode 2 low byte counts, reloads from high byte and flags on overflow
// - Timer 0 clock-out enable toggles its pin latch on each overflow
// - Timer 1 clock-out enable toggles its pin on every timer 1 overflow
// - Timer 1 in mode 3 holds its count as if stopped
// - Timer 0 mode 3: low byte full timer, high byte on timer 1 controls
// - Overflow flags clear on interrupt vectoring; software may set or clear
// - Ext flag set on fall or low level per type bit; cleared on service in edge mode
// - Ext pin levels are inverted into the flags every clock in level mode
// - Edge mode sets ext flag when a high sample is followed by low
`default_nettype none
package dtc_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_TCTL = 8'h88;
    localparam logic [7:0] ADDR_TMODE = 8'h89;
    localparam logic [7:0] ADDR_TL0 = 8'h8a;
    localparam logic [7:0] ADDR_TL1 = 8'h8b;
    localparam logic [7:0] ADDR_TH0 = 8'h8c;
    localparam logic [7:0] ADDR_TH1 = 8'h8d;
    localparam logic [7:0] ADDR_AUX = 8'h8e;
    localparam logic [7:0] ADDR_CLKO = 8'h8f;

    // Reset value of every register
    localparam logic [7:0] RST_REG = 8'h00;

    // timer_control bit positions
    localparam int TC_OVF1 = 7;
    localparam int TC_RUN1 = 6;
    localparam int TC_OVF0 = 5;
    localparam int TC_RUN0 = 4;
    localparam int TC_XF1 = 3;
    localparam int TC_XT1 = 2;
    localparam int TC_XF0 = 1;
    localparam int TC_XT0 = 0;

    // timer_mode_select bit positions
    localparam int TM_GATE1 = 7;
    localparam int TM_FUNC1 = 6;
    localparam int TM_MODE1 = 4;
    localparam int TM_GATE0 = 3;
    localparam int TM_FUNC0 = 2;
    localparam int TM_MODE0 = 0;

    // auxiliary_config and clock_out_wake_control bit positions
    localparam int AUX_DIV0 = 7;
    localparam int AUX_DIV1 = 6;
    localparam int CK_EN0 = 0;
    localparam int CK_EN1 = 1;
    localparam logic [7:0] CLKO_MASK = 8'h77;

    // Machine cycle prescaler
    localparam int PRE_DIV = 12;
    localparam int PRE_W = 4;

    typedef enum logic [1:0] {
        DTC_MODE_13,
        DTC_MODE_16,
        DTC_MODE_RELOAD,
        DTC_MODE_SPLIT
    } dtc_mode_t;

    // Result of one count step
    typedef struct packed {
        logic ovf;
        logic [7:0] th;
        logic [7:0] tl;
    } dtc_step_t;

    // Prescaler state
    typedef struct packed {
        logic [PRE_W-1:0] cnt;
        logic tick;
    } dtc_pre_t;

    // Main block state
    typedef struct packed {
        logic [7:0] tctl;
        logic [7:0] tmode;
        logic [7:0] tl0;
        logic [7:0] tl1;
        logic [7:0] th0;
        logic [7:0] th1;
        logic [7:0] aux;
        logic [7:0] clko;
        logic [1:0] clk_lat;
        logic [1:0] ovf;
        logic [7:0] rdata;
    } dtc_state_t;

endpackage : dtc_pkg
`default_nettype wire

// ==== rtl/dtc_prescale.sv ====
// Machine cycle tick generator for the timer/counter block
`timescale 1ns/1ps
`default_nettype none
module dtc_prescale (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    output logic tick_o
);
    localparam logic [dtc_pkg::PRE_W-1:0] LAST =
        dtc_pkg::PRE_W'(dtc_pkg::PRE_DIV - 1);

    dtc_pkg::dtc_pre_t s_ff;
    dtc_pkg::dtc_pre_t nxt_s;

    // Free-running divider; tick is high one clock in every twelve
    always_comb begin
        nxt_s = s_ff;
        nxt_s.tick = 1'b0;
        if (s_ff.cnt == LAST) begin
            nxt_s.cnt = '0;
            nxt_s.tick = 1'b1;
        end else begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_ff <= '0;
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    assign tick_o = s_ff.tick;
endmodule : dtc_prescale
`default_nettype wire

// ==== rtl/dtc_top.sv ====
// Dual timer/counter with clock outputs and external interrupt flags
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dtc_top (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [1:0] count_pin_i,
    input wire logic [1:0] ext_irq_pin_i,
    input wire logic [1:0] tmr_ack_i,
    input wire logic [1:0] ext_ack_i,
    output logic [7:0] rdata_o,
    output logic [1:0] ovf_pulse_o,
    output logic [1:0] tmr_flag_o,
    output logic [1:0] ext_flag_o,
    output logic [1:0] clk_out_o,
    output logic [1:0] clk_out_oe_o
);

    dtc_pkg::dtc_state_t s_ff;
    dtc_pkg::dtc_state_t nxt_s;

    logic mc_tick;
    logic [3:0] fall;

    // One machine cycle is twelve system clocks
    dtc_prescale u_pre (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .tick_o(mc_tick)
    );

    // Bits 1:0 are the count pins, bits 3:2 the interrupt pins
    dtc_edge #(
        .W(4)
    ) u_edge (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .pin_i({ext_irq_pin_i, count_pin_i}),
        .fall_o(fall)
    );

    // One count step of a timer in the given mode
    function automatic dtc_pkg::dtc_step_t dtc_step(
        input dtc_pkg::dtc_mode_t m,
        input logic [7:0] th,
        input logic [7:0] tl
    );
        dtc_pkg::dtc_step_t r;
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        r.ovf = 1'b0;
        r.th = th;
        r.tl = tl;
        s13 = {1'b0, th, tl[4:0]} + 14'h0001;
        s16 = {1'b0, th, tl} + 17'h00001;
        s8 = {1'b0, tl} + 9'h001;
        case (m)
            dtc_pkg::DTC_MODE_13: begin
                // Upper three low-byte bits are left alone
                r.th = s13[12:5];
                r.tl = {tl[7:5], s13[4:0]};
                r.ovf = s13[13];
            end
            dtc_pkg::DTC_MODE_16: begin
                r.th = s16[15:8];
                r.tl = s16[7:0];
                r.ovf = s16[16];
            end
            dtc_pkg::DTC_MODE_RELOAD: begin
                r.tl = s8[8] ? th : s8[7:0];
                r.ovf = s8[8];
            end
            dtc_pkg::DTC_MODE_SPLIT: begin
                // Low byte only; the high byte is stepped by the caller
                r.tl = s8[7:0];
                r.ovf = s8[8];
            end
            default: begin
                r.ovf = 1'b0;
            end
        endcase
        return r;
    endfunction : dtc_step

    // Decoded mode fields
    dtc_pkg::dtc_mode_t mode0;
    dtc_pkg::dtc_mode_t mode1;
    assign mode0 = dtc_pkg::dtc_mode_t'(
        s_ff.tmode[dtc_pkg::TM_MODE0 +: 2]);
    assign mode1 = dtc_pkg::dtc_mode_t'(
        s_ff.tmode[dtc_pkg::TM_MODE1 +: 2]);

    // Time base per timer: prescaled machine cycle or every clock
    logic rate0;
    logic rate1;
    assign rate0 = s_ff.aux[dtc_pkg::AUX_DIV0] ? 1'b1 : mc_tick;
    assign rate1 = s_ff.aux[dtc_pkg::AUX_DIV1] ? 1'b1 : mc_tick;

    // Count source; the edge pulse is already one cycle late, so the new
    // value lands at the end of the cycle after detection
    logic src0;
    logic src1;
    assign src0 = s_ff.tmode[dtc_pkg::TM_FUNC0] ?
        fall[0] : rate0;
    assign src1 = s_ff.tmode[dtc_pkg::TM_FUNC1] ?
        fall[1] : rate1;

    // Run and gate qualification
    logic en0;
    logic en1;
    assign en0 = s_ff.tctl[dtc_pkg::TC_RUN0] &
        (~s_ff.tmode[dtc_pkg::TM_GATE0] | ext_irq_pin_i[0]);
    assign en1 = s_ff.tctl[dtc_pkg::TC_RUN1] &
        (~s_ff.tmode[dtc_pkg::TM_GATE1] | ext_irq_pin_i[1]);

    // Count enables; a timer 1 in mode 3 is simply frozen
    logic split0;
    logic inc0;
    logic inc1;
    logic inc_h0;
    assign split0 = (mode0 == dtc_pkg::DTC_MODE_SPLIT);
    assign inc0 = en0 & src0;
    assign inc1 = en1 & src1 & (mode1 != dtc_pkg::DTC_MODE_SPLIT);
    // Split high byte counts timer 0's time base, never the pin, on timer 1's run bit
    assign inc_h0 = split0 & s_ff.tctl[dtc_pkg::TC_RUN1] & rate0;

    // Step results
    dtc_pkg::dtc_step_t st0;
    dtc_pkg::dtc_step_t st1;
    logic [8:0] h0_sum;
    assign st0 = dtc_step(mode0, s_ff.th0, s_ff.tl0);
    assign st1 = dtc_step(mode1, s_ff.th1, s_ff.tl1);
    assign h0_sum = {1'b0, s_ff.th0} + 9'h001;

    // Overflow events
    logic ev_t0;
    logic ev_t1;
    logic ev_h0;
    logic set_tf1;
    assign ev_t0 = inc0 & st0.ovf;
    assign ev_t1 = inc1 & st1.ovf;
    assign ev_h0 = inc_h0 & h0_sum[8];
    // While timer 0 is split its high byte owns the timer 1 flag
    assign set_tf1 = split0 ? ev_h0 : ev_t1;

    // Read data mux; unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        case (addr_i)
            dtc_pkg::ADDR_TCTL: rd_mux = s_ff.tctl;
            dtc_pkg::ADDR_TMODE: rd_mux = s_ff.tmode;
            dtc_pkg::ADDR_TL0: rd_mux = s_ff.tl0;
            dtc_pkg::ADDR_TL1: rd_mux = s_ff.tl1;
            dtc_pkg::ADDR_TH0: rd_mux = s_ff.th0;
            dtc_pkg::ADDR_TH1: rd_mux = s_ff.th1;
            dtc_pkg::ADDR_AUX: rd_mux = s_ff.aux;
            dtc_pkg::ADDR_CLKO: rd_mux = s_ff.clko;
            default: rd_mux = 8'h00;
        endcase
    end

    // Next state: counting first, then software writes, then hardware
    // flag sets so a set in the clearing cycle is never lost
    always_comb begin
        nxt_s = s_ff;
        nxt_s.ovf = {ev_t1, ev_t0};
        nxt_s.rdata = rd_i ? rd_mux : 8'h00;

        // Counting
        if (inc0) begin
            nxt_s.th0 = st0.th;
            nxt_s.tl0 = st0.tl;
        end
        if (inc_h0) begin
            nxt_s.th0 = h0_sum[7:0];
        end
        if (inc1) begin
            nxt_s.th1 = st1.th;
            nxt_s.tl1 = st1.tl;
        end

        // Software writes win over a count in the same cycle
        if (wr_i) begin
            case (addr_i)
                // Run bits change control only; counts stay as they are
                dtc_pkg::ADDR_TCTL: nxt_s.tctl = wdata_i;
                dtc_pkg::ADDR_TMODE: nxt_s.tmode = wdata_i;
                dtc_pkg::ADDR_TL0: nxt_s.tl0 = wdata_i;
                dtc_pkg::ADDR_TL1: nxt_s.tl1 = wdata_i;
                dtc_pkg::ADDR_TH0: nxt_s.th0 = wdata_i;
                dtc_pkg::ADDR_TH1: nxt_s.th1 = wdata_i;
                dtc_pkg::ADDR_AUX: nxt_s.aux = wdata_i;
                dtc_pkg::ADDR_CLKO: nxt_s.clko = wdata_i & dtc_pkg::CLKO_MASK;
                default: nxt_s.rdata = nxt_s.rdata;
            endcase
        end

        // Interrupt vectoring clears the timer flags
        if (tmr_ack_i[0]) begin
            nxt_s.tctl[dtc_pkg::TC_OVF0] = 1'b0;
        end
        if (tmr_ack_i[1]) begin
            nxt_s.tctl[dtc_pkg::TC_OVF1] = 1'b0;
        end
        if (ev_t0) begin
            nxt_s.tctl[dtc_pkg::TC_OVF0] = 1'b1;
        end
        if (set_tf1) begin
            nxt_s.tctl[dtc_pkg::TC_OVF1] = 1'b1;
        end

        // External flag 0: level mode mirrors the inverted pin every clock
        if (!s_ff.tctl[dtc_pkg::TC_XT0]) begin
            nxt_s.tctl[dtc_pkg::TC_XF0] = ~ext_irq_pin_i[0];
        end else begin
            if (ext_ack_i[0]) begin
                nxt_s.tctl[dtc_pkg::TC_XF0] = 1'b0;
            end
            if (fall[2]) begin
                nxt_s.tctl[dtc_pkg::TC_XF0] = 1'b1;
            end
        end

        // External flag 1, same scheme
        if (!s_ff.tctl[dtc_pkg::TC_XT1]) begin
            nxt_s.tctl[dtc_pkg::TC_XF1] = ~ext_irq_pin_i[1];
        end else begin
            if (ext_ack_i[1]) begin
                nxt_s.tctl[dtc_pkg::TC_XF1] = 1'b0;
            end
            if (fall[3]) begin
                nxt_s.tctl[dtc_pkg::TC_XF1] = 1'b1;
            end
        end

        // Clock-out latches toggle per overflow, giving half the rate
        if (s_ff.clko[dtc_pkg::CK_EN0] && ev_t0) begin
            nxt_s.clk_lat[0] = ~s_ff.clk_lat[0];
        end
        if (s_ff.clko[dtc_pkg::CK_EN1] && ev_t1) begin
            nxt_s.clk_lat[1] = ~s_ff.clk_lat[1];
        end
    end

    // All state in one register; clock enable low freezes everything
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_ff <= '0;
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from state flops
    assign rdata_o = s_ff.rdata;
    assign ovf_pulse_o = s_ff.ovf;
    assign tmr_flag_o = {s_ff.tctl[dtc_pkg::TC_OVF1],
        s_ff.tctl[dtc_pkg::TC_OVF0]};
    assign ext_flag_o = {s_ff.tctl[dtc_pkg::TC_XF1],
        s_ff.tctl[dtc_pkg::TC_XF0]};
    assign clk_out_o = s_ff.clk_lat;
    assign clk_out_oe_o = {s_ff.clko[dtc_pkg::CK_EN1],
        s_ff.clko[dtc_pkg::CK_EN0]};

endmodule : dtc_top
`default_nettype wire
